/* design/pulse_seg_pkg.sv */
// constants, types and helpers for the arbitrary pulse segment register bank
package pulse_seg_pkg;
   localparam int CHANNELS = 4;
   localparam int SEGMENTS = 5;
   localparam int SEG_IDX_W = 3;

   // register indices for channel 0; byte address is four times the index
   localparam logic [15:0] SEG_ONE_IDX   = 16'h0f08;
   localparam logic [15:0] SEG_TWO_IDX   = 16'h0f09;
   localparam logic [15:0] SEG_THREE_IDX = 16'h0f0a;
   localparam logic [15:0] SEG_FOUR_IDX  = 16'h0f0b;
   localparam logic [15:0] SEG_FIVE_IDX  = 16'h0f0c;
   localparam logic [15:0] EQ_CTRL_IDX   = 16'h0f00;
   localparam int          CHAN_LSB      = 4;
   localparam logic [7:0]  BANK_PAGE     = 8'h0f;

   localparam logic [7:0] SEG_RESET     = 8'h00;
   localparam int         SIGN_BIT      = 6;
   localparam logic [4:0] EQC_ARBITRARY = 5'h1f;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [7:0] seg_reg_t;
   typedef logic [SEG_IDX_W-1:0] seg_idx_t;
   typedef logic [1:0] chan_t;

   typedef struct packed {
      logic     hit;
      chan_t    chan;
      seg_idx_t seg;
   } reg_hit_t;

   typedef enum {SEQ_IDLE, SEQ_SHAPE} seq_state_t;

   // byte address to channel and segment slot
   function automatic reg_hit_t decode_addr(input logic [31:0] addr);
      reg_hit_t   r;
      logic [15:0] idx;
      logic [15:0] base;
      idx    = addr[17:2];
      base   = {idx[15:8], 4'h0, idx[3:0]};
      r.hit  = (addr[31:18] == 14'h0000) && (addr[1:0] == 2'h0) && (idx[15:8] == BANK_PAGE)
               && (32'(idx[7:CHAN_LSB]) < CHANNELS);
      r.chan = idx[CHAN_LSB+1:CHAN_LSB];
      r.seg  = 3'h0;
      case (base)
         SEG_ONE_IDX:   r.seg = 3'h0; // R1
         SEG_TWO_IDX:   r.seg = 3'h1; // R2
         SEG_THREE_IDX: r.seg = 3'h2; // R3
         SEG_FOUR_IDX:  r.seg = 3'h3; // R4
         SEG_FIVE_IDX:  r.seg = 3'h4; // R5
         default:       r.hit = 1'b0;
      endcase
      return r;
   endfunction

   // sign-magnitude segment field to two's complement
   function automatic logic signed [7:0] seg_to_signed(input seg_reg_t v);
      logic [7:0] mag;
      mag = {2'h0, v[SIGN_BIT-1:0]};
      return v[SIGN_BIT] ? 8'(-mag) : mag; // R6
   endfunction
endpackage

/* design/pulse_segment_regs.sv */
// arbitrary transmit pulse segment registers with an axi4-lite slave
//
// Notes on behaviour
// R1: each channel has a register at 0x0Fn8 holding segment one amplitude in bits 6-0.
// R2: each channel has a register at 0x0Fn9 holding segment two amplitude.
// R3: each channel has a register at 0x0FnA holding segment three amplitude.
// R4: each channel has a register at 0x0FnB holding segment four amplitude.
// R5: each channel has a register at 0x0FnC holding segment five amplitude.
// R6: amplitudes are sign-magnitude, bit 6 the sign, bit 0 the magnitude lsb.
// R7: stored amplitudes shape the pulse only when equalizer control selects arbitrary mode.
// R8: in arbitrary mode segments are applied in ascending order, starting with segment one.
`timescale 1ns/100ps
module pulse_segment_regs
(
   // clock and reset
   input  wire  logic                                         aclk,
   input  wire  logic                                         aresetn,
   input  wire  logic                                         clk_en,
   // axi4-lite write address
   input  wire  logic [31:0]                                  s_axi_awaddr,
   input  wire  logic [2:0]                                   s_axi_awprot,
   input  wire  logic                                         s_axi_awvalid,
   output       logic                                         s_axi_awready,
   // axi4-lite write data
   input  wire  logic [31:0]                                  s_axi_wdata,
   input  wire  logic [3:0]                                   s_axi_wstrb,
   input  wire  logic                                         s_axi_wvalid,
   output       logic                                         s_axi_wready,
   // axi4-lite write response
   output       logic [1:0]                                   s_axi_bresp,
   output       logic                                         s_axi_bvalid,
   input  wire  logic                                         s_axi_bready,
   // axi4-lite read address
   input  wire  logic [31:0]                                  s_axi_araddr,
   input  wire  logic [2:0]                                   s_axi_arprot,
   input  wire  logic                                         s_axi_arvalid,
   output       logic                                         s_axi_arready,
   // axi4-lite read data
   output       logic [31:0]                                  s_axi_rdata,
   output       logic [1:0]                                   s_axi_rresp,
   output       logic                                         s_axi_rvalid,
   input  wire  logic                                         s_axi_rready,
   // line interface side
   input  wire  logic [pulse_seg_pkg::CHANNELS-1:0][4:0]      equalizer_control_field,
   input  wire  logic [pulse_seg_pkg::CHANNELS-1:0]           tx_pulse_start,
   // shaped pulse to the transmit driver
   output       logic [pulse_seg_pkg::CHANNELS-1:0][7:0]      shape_amplitude,
   output       logic [pulse_seg_pkg::CHANNELS-1:0][2:0]      shape_segment,
   output       logic [pulse_seg_pkg::CHANNELS-1:0]           shape_active
);
   import pulse_seg_pkg::*;

   seg_reg_t    seg_q [CHANNELS][SEGMENTS];
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;
   logic [31:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   // bus handshakes and decode
   wire      aw_take   = s_axi_awvalid && awready_q;
   wire      w_take    = s_axi_wvalid && wready_q;
   wire      b_done    = bvalid_q && s_axi_bready;
   wire      ar_take   = s_axi_arvalid && arready_q;
   wire      r_done    = rvalid_q && s_axi_rready;
   wire      wr_ready  = !awready_q && !wready_q && !bvalid_q;
   reg_hit_t wr_hit;
   reg_hit_t rd_hit;
   assign wr_hit = decode_addr(waddr_q);
   assign rd_hit = decode_addr(s_axi_araddr);
   wire      wr_store  = wr_ready && wr_hit.hit && wstrb_q[0];
   wire [31:0] rd_word = rd_hit.hit ? {24'h000000, seg_q[rd_hit.chan][rd_hit.seg]} : 32'h00000000;

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   // write address and data, accepted in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         waddr_q   <= 32'h00000000;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end
      else if (clk_en)
      begin
         if (aw_take)
         begin
            awready_q <= 1'b0;
            waddr_q   <= s_axi_awaddr;
         end
         else if (b_done)
            awready_q <= 1'b1;
         if (w_take)
         begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         else if (b_done)
            wready_q <= 1'b1;
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (wr_ready)
         begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit.hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (b_done)
            bvalid_q <= 1'b0;
      end
   end

   // segment storage, all eight bits kept, only bits 6-0 feed the shaper
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int c = 0; c < CHANNELS; c++)
            for (int s = 0; s < SEGMENTS; s++)
               seg_q[c][s] <= SEG_RESET;
      end
      else if (clk_en && wr_store)
         seg_q[wr_hit.chan][wr_hit.seg] <= wdata_q[7:0]; // R1 R2 R3 R4 R5
   end

   // read channel, one answer per address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= 32'h00000000;
      end
      else if (clk_en)
      begin
         if (ar_take)
         begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_hit.hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (r_done)
         begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // one sequencer per channel
   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_chan
      seg_bus_if bus ();
      for (genvar s = 0; s < SEGMENTS; s++)
      begin : g_seg
         assign bus.seg[s] = seg_q[c][s];
      end
      assign bus.arb_mode = (equalizer_control_field[c] == EQC_ARBITRARY); // R7
      assign bus.start    = tx_pulse_start[c];

      segment_sequencer u_seq
      (
         .aclk        (aclk),
         .aresetn     (aresetn),
         .clk_en      (clk_en),
         .bus         (bus.seq),
         .amplitude_q (shape_amplitude[c]),
         .segment_q   (shape_segment[c]),
         .active_q    (shape_active[c])
      );
   end
endmodule

/* design/seg_bus_if.sv */
// segment values and mode handed from the register bank to one channel's sequencer
`timescale 1ns/100ps
interface seg_bus_if;
   import pulse_seg_pkg::*;
   seg_reg_t seg [SEGMENTS];
   logic     arb_mode;
   logic     start;
   modport regs (output seg, output arb_mode, output start);
   modport seq  (input seg, input arb_mode, input start);
endinterface

/* design/segment_sequencer.sv */
// steps one channel's pulse through its segment amplitudes
`timescale 1ns/100ps
module segment_sequencer
(
   // clock and reset
   input  wire  logic               aclk,
   input  wire  logic               aresetn,
   input  wire  logic               clk_en,
   // segment values
   seg_bus_if.seq                   bus,
   // shaped output
   output       logic signed [7:0]  amplitude_q,
   output       logic [2:0]         segment_q,
   output       logic               active_q
);
   import pulse_seg_pkg::*;

   seq_state_t state_q;
   seg_idx_t   idx_q;
   wire        last_seg = (idx_q == seg_idx_t'(SEGMENTS - 1));
   wire        launch   = bus.start && bus.arb_mode; // R7

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q     <= SEQ_IDLE;
         idx_q       <= '0;
         amplitude_q <= '0;
         segment_q   <= '0;
         active_q    <= 1'b0;
      end
      else if (clk_en)
      begin
         case (state_q)
            SEQ_IDLE:
            begin
               if (launch)
               begin
                  state_q     <= SEQ_SHAPE;
                  idx_q       <= '0;
                  amplitude_q <= seg_to_signed(bus.seg[0]); // R8
                  segment_q   <= 3'h1;
                  active_q    <= 1'b1;
               end
            end
            SEQ_SHAPE:
            begin
               if (!bus.arb_mode || (last_seg && !launch))
               begin
                  state_q     <= SEQ_IDLE; // R7
                  amplitude_q <= '0;
                  segment_q   <= '0;
                  active_q    <= 1'b0;
               end
               else if (last_seg)
               begin
                  idx_q       <= '0;
                  amplitude_q <= seg_to_signed(bus.seg[0]); // R8
                  segment_q   <= 3'h1;
               end
               else
               begin
                  idx_q       <= idx_q + 3'h1;
                  amplitude_q <= seg_to_signed(bus.seg[idx_q + 3'h1]); // R8
                  segment_q   <= idx_q + 3'h2;
               end
            end
            default:
            begin
               state_q  <= SEQ_IDLE;
               active_q <= 1'b0;
            end
         endcase
      end
   end
endmodule

/* dv/pulse_segment_regs_properties.sv */
// concurrent checks on the pulse segment register bank ports
`timescale 1ns/100ps
module pulse_segment_regs_properties
(
   // clock and reset
   input wire logic                                    aclk,
   input wire logic                                    aresetn,
   input wire logic                                    clk_en,
   // register bus
   input wire logic                                    s_axi_arvalid,
   input wire logic                                    s_axi_arready,
   input wire logic [31:0]                             s_axi_rdata,
   input wire logic [1:0]                              s_axi_rresp,
   input wire logic                                    s_axi_rvalid,
   input wire logic                                    s_axi_rready,
   input wire logic [1:0]                              s_axi_bresp,
   input wire logic                                    s_axi_bvalid,
   input wire logic                                    s_axi_bready,
   // line side
   input wire logic [pulse_seg_pkg::CHANNELS-1:0][4:0] equalizer_control_field,
   input wire logic [pulse_seg_pkg::CHANNELS-1:0]      tx_pulse_start,
   input wire logic [pulse_seg_pkg::CHANNELS-1:0][2:0] shape_segment,
   input wire logic [pulse_seg_pkg::CHANNELS-1:0]      shape_active
);
   import pulse_seg_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire arb0 = clk_en && equalizer_control_field[0] == EQC_ARBITRARY;
   sequence arb_go;
      arb0 && tx_pulse_start[0] && !shape_active[0];
   endsequence
   sequence arb_mid;
      arb0 && shape_active[0] && shape_segment[0] != 3'h5;
   endsequence
   AST_RD_LAT: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_RD_HOLD: assert property (clk_en && s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   AST_B_HOLD: assert property (clk_en && s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   AST_RD_WIDTH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_RD_ERR: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_LEAVE: assert property (clk_en && equalizer_control_field[0] != EQC_ARBITRARY |=> !shape_active[0])
      else $error("shaping outside arbitrary mode");
   AST_START: assert property (arb_go |=> shape_active[0] && shape_segment[0] == 3'h1)
      else $error("pulse did not start at segment one");
   AST_STEP: assert property (arb_mid |=> shape_segment[0] == $past(shape_segment[0]) + 3'h1)
      else $error("segment order broken");
   AST_END: assert property (arb0 && shape_segment[0] == 3'h5 && !tx_pulse_start[0] |=> !shape_active[0])
      else $error("pulse did not end after segment five");
endmodule
bind pulse_segment_regs pulse_segment_regs_properties chk_u (.aclk, .aresetn, .clk_en, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .equalizer_control_field, .tx_pulse_start, .shape_segment, .shape_active);

/* dv/pulse_segment_regs_tb_top.sv */
// self-checking bench for the pulse segment register bank
`timescale 1ns/100ps
module pulse_segment_regs_tb_top;
   import pulse_seg_pkg::*;
   logic                     aclk = 0, aresetn = 0, clk_en = 1;
   logic [31:0]              s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
   logic [3:0]               s_axi_wstrb = 0;
   logic [2:0]               s_axi_awprot = 0, s_axi_arprot = 0;
   logic                     s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic                     s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]               s_axi_bresp, s_axi_rresp, rsp;
   logic [CHANNELS-1:0][4:0] equalizer_control_field = '0;
   logic [CHANNELS-1:0]      tx_pulse_start = '0, shape_active;
   logic [CHANNELS-1:0][7:0] shape_amplitude;
   logic [CHANNELS-1:0][2:0] shape_segment;
   logic [31:0]              bad [3] = '{32'h3c00, 32'h3c34, 32'h3c21};
   int                       n_fail = 0, tests_run = 0;
   pulse_segment_regs dut_u (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .equalizer_control_field, .tx_pulse_start, .shape_amplitude,
      .shape_segment, .shape_active);
   initial
   begin
      forever #50 aclk = ~aclk;
   end
   function automatic logic [31:0] adr(int c, int s);
      return 32'h3c20 + 32'(c) * 32'h40 + 32'(s) * 32'h4;
   endfunction
   function automatic logic [7:0] pat(int c, int s);
      return 8'(c * 5 + s) * 8'h1d + 8'h47;
   endfunction
   function automatic logic [7:0] sm(logic [7:0] v);
      return v[6] ? 8'h00 - {2'h0, v[5:0]} : {2'h0, v[5:0]};
   endfunction
   task automatic close_out;
      $display("checks %0d errors %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // late holds the ready low until the answer is seen, then raises it for the one cycle of the handshake
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input bit late);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !late;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end
      while (!(s_axi_bvalid && s_axi_bready));
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdt(input logic [31:0] a, input bit late);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !late;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end
      while (!(s_axi_rvalid && s_axi_rready));
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   initial
   begin
      repeat (5000) @(posedge aclk);
      n_fail++;
      close_out;
   end
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int c = 0; c < CHANNELS; c++)
         for (int s = 0; s < SEGMENTS; s++)
         begin
            rdt(adr(c, s), 1'b0);
            chk("reset value", 32'(SEG_RESET), rd);
            wr(adr(c, s), {24'h0, pat(c, s)}, 4'hf, 1'b0);
            chk("write resp", 32'(RESP_OKAY), 32'(rsp));
         end
      wr(adr(2, 1), 32'h0, 4'h0, 1'b1);
      chk("masked resp", 32'(RESP_OKAY), 32'(rsp));
      for (int c = 0; c < CHANNELS; c++)
         for (int s = 0; s < SEGMENTS; s++)
         begin
            rdt(adr(c, s), 1'b0);
            chk("readback", {24'h0, pat(c, s)}, rd);
         end
      foreach (bad[i])
      begin
         wr(bad[i], 32'hff, 4'hf, 1'b0);
         chk("unmapped wr", 32'(RESP_SLVERR), 32'(rsp));
         rdt(bad[i], 1'b0);
         chk("unmapped rd", 32'(RESP_SLVERR), 32'(rsp));
         chk("unmapped data", 32'h0, rd);
      end
      rdt(adr(0, 0), 1'b1);
      chk("seg one kept", {24'h0, pat(0, 0)}, rd);
      tx_pulse_start <= 4'h9;
      repeat (2) @(posedge aclk);
      #1 chk("off mode", 32'h0, 32'(shape_active));
      @(posedge aclk);
      equalizer_control_field[0] <= EQC_ARBITRARY;
      equalizer_control_field[3] <= EQC_ARBITRARY;
      @(posedge aclk);
      tx_pulse_start <= 4'h0;
      for (int k = 1; k <= SEGMENTS; k++)
      begin
         #1 chk("segment", 32'(k), 32'(shape_segment[0]));
         chk("amplitude", 32'(sm(pat(0, k - 1))), 32'(shape_amplitude[0]));
         chk("segment ch3", 32'(k), 32'(shape_segment[3]));
         chk("amplitude ch3", 32'(sm(pat(3, k - 1))), 32'(shape_amplitude[3]));
         @(posedge aclk);
      end
      #1 chk("idle", 32'h0, 32'(shape_active));
      @(posedge aclk);
      tx_pulse_start[0] <= 1'b1;
      @(posedge aclk);
      #1 chk("second start", 32'h1, 32'(shape_segment[0]));
      repeat (4) @(posedge aclk);
      #1 chk("last before restart", 32'h5, 32'(shape_segment[0]));
      @(posedge aclk);
      tx_pulse_start[0] <= 1'b0;
      clk_en <= 1'b0;
      #1 chk("restart", 32'h1, 32'(shape_segment[0]));
      repeat (2) @(posedge aclk);
      clk_en <= 1'b1;
      #1 chk("frozen", 32'h1, 32'(shape_segment[0]));
      @(posedge aclk);
      equalizer_control_field[0] <= 5'h00;
      #1 chk("thawed", 32'h2, 32'(shape_segment[0]));
      @(posedge aclk);
      #1 chk("left mode", 32'h0, 32'(shape_active[0]));
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdt(adr(1, 2), 1'b0);
      chk("reset again", 32'(SEG_RESET), rd);
      close_out;
   end
endmodule
